/* File: wdg_map.svh */
// Register offsets, reset values and timing constants for the slave watchdog
`ifndef WDG_MAP_SVH
`define WDG_MAP_SVH
`define PRESCALER_OFS 16'h0400
`define LOCAL_WDG_OFS 16'h0410
`define BUS_WDG_OFS 16'h0420
`define STATE_REQ_OFS 16'h0120
`define STATE_ACK_OFS 16'h0130
`define WDG_STATUS_OFS 16'h0440
`define SAFE_VALUE_OFS 16'h0F00
`define OUT_DATA_OFS 16'h0F10
`define PRESCALER_RST 16'h09C2
`define BUS_WDG_RST 16'h03E8
`define LOCAL_WDG_RST 16'h03E8
`define BASE_TICK_NS 40
`define CLK_PERIOD_NS 5
`define BASE_DIV (`BASE_TICK_NS / `CLK_PERIOD_NS)
`define PRESCALER_EXTRA 2
`endif

/* File: wdg_pkg.sv */
// Types shared by both ends of the slave control link
package wdg_pkg;
    typedef enum logic [2:0] {
        ST_INIT = 3'h1,
        ST_CONFIG = 3'h2,
        ST_BOOT = 3'h3,
        ST_GUARDED = 3'h4,
        ST_RUN = 3'h0
    } slave_state_t;
    typedef enum logic [1:0] {
        KIND_REG = 2'h0,
        KIND_MAILBOX = 2'h1,
        KIND_FILE = 2'h2,
        KIND_PROCESS = 2'h3
    } access_kind_t;
endpackage

/* File: slave_link_if.sv */
// Interface joining the bus master end and the slave controller end
`timescale 1ns/100ps
interface slave_link_if;
    logic req;
    logic wr;
    wdg_pkg::access_kind_t kind;
    logic [15:0] addr;
    logic [15:0] wdata;
    logic ack;
    logic err;
    logic [15:0] rdata;
    modport master(output req, wr, kind, addr, wdata,
        input ack, err, rdata);
    modport slave(input req, wr, kind, addr, wdata,
        output ack, err, rdata);
endinterface

/* File: slave_controller.sv */
// Slave controller: watchdogs, register map and slave state machine
`timescale 1ns/100ps
`include "wdg_map.svh"
module slave_controller #(
    parameter int WIDTH = 16,
    parameter int IO_WIDTH = 8
) (
    input wire logic REF_CLK,
    input wire logic RST_B,
    slave_link_if.slave LINK,
    input wire logic LOCAL_ACCESS,
    input wire logic MAILBOX_CFG_OK,
    input wire logic PROCESS_CFG_OK,
    input wire logic [IO_WIDTH-1:0] INPUTS,
    output logic [IO_WIDTH-1:0] OUTPUTS,
    output logic [IO_WIDTH-1:0] INPUT_IMAGE,
    output logic BUS_WDG_EXPIRED,
    output logic LOCAL_WDG_EXPIRED,
    output logic [2:0] STATE
);
    localparam logic [3:0] BASE_DIV_M1 = 4'(`BASE_DIV - 1);
    logic [3:0] base_cnt_q;
    logic [WIDTH-1:0] pre_cnt_q;
    logic [WIDTH-1:0] prescaler_q, local_time_q, bus_time_q;
    logic [WIDTH-1:0] bus_cnt_q, local_cnt_q;
    logic [IO_WIDTH-1:0] safe_q, out_data_q, image_q, outputs_q;
    logic bus_exp_q, local_exp_q;
    wdg_pkg::slave_state_t state_q;
    logic ack_q, err_q;
    logic [15:0] rdata_q;

    wire base_tick = (base_cnt_q == BASE_DIV_M1);
    wire [WIDTH:0] pre_limit = {1'b0, prescaler_q} + (WIDTH+1)'(1);
    // Catches up at once when the prescaler shrinks
    wire wdg_tick = base_tick && ({1'b0, pre_cnt_q} >= pre_limit);
    wire is_proc = LINK.kind == wdg_pkg::KIND_PROCESS;
    wire is_mbx = LINK.kind == wdg_pkg::KIND_MAILBOX;
    wire is_file = LINK.kind == wdg_pkg::KIND_FILE;
    wire in_run = state_q == wdg_pkg::ST_RUN;
    wire in_guard = state_q == wdg_pkg::ST_GUARDED;
    wire in_cfg = state_q == wdg_pkg::ST_CONFIG;
    wire in_boot = state_q == wdg_pkg::ST_BOOT;
    wire proc_ok = in_guard || in_run;
    wire mbx_ok = in_cfg || in_guard || in_run;
    wire file_ok = mbx_ok || in_boot;
    wire allowed = (LINK.kind == wdg_pkg::KIND_REG) || (is_proc && proc_ok)
        || (is_mbx && mbx_ok) || (is_file && file_ok);
    wire take = LINK.req && !ack_q;
    wire good = take && allowed;
    wire proc_done = good && is_proc;
    wire reg_wr = good && LINK.wr && LINK.kind == wdg_pkg::KIND_REG;
    wire proc_wr = proc_done && LINK.wr;
    wire [IO_WIDTH-1:0] wlow = LINK.wdata[IO_WIDTH-1:0];
    wire [15:0] rd_mux =
        (LINK.addr == `PRESCALER_OFS) ? 16'(prescaler_q) :
        (LINK.addr == `LOCAL_WDG_OFS) ? 16'(local_time_q) :
        (LINK.addr == `BUS_WDG_OFS) ? 16'(bus_time_q) :
        (LINK.addr == `STATE_ACK_OFS) ? {13'h0000, state_q} :
        (LINK.addr == `WDG_STATUS_OFS) ? {14'h0000, local_exp_q, bus_exp_q} :
        (LINK.addr == `SAFE_VALUE_OFS) ? 16'(safe_q) :
        (is_proc) ? 16'(image_q) : 16'h0000;
    wire bus_en = bus_time_q != '0;
    wire local_en = local_time_q != '0;
    wire st_wr = reg_wr && LINK.addr == `STATE_REQ_OFS;
    wire [2:0] rq = LINK.wdata[2:0];
    wire go_cfg = in_boot ? rq == 3'(wdg_pkg::ST_INIT) :
        MAILBOX_CFG_OK && rq == 3'(wdg_pkg::ST_CONFIG) &&
        state_q == wdg_pkg::ST_INIT;
    wire go_boot = rq == 3'(wdg_pkg::ST_BOOT) && state_q == wdg_pkg::ST_INIT;
    wire go_guard = rq == 3'(wdg_pkg::ST_GUARDED) && PROCESS_CFG_OK &&
        (in_cfg || in_run);
    wire go_run = rq == 3'(wdg_pkg::ST_RUN) && in_guard;
    wire go_down = (rq == 3'(wdg_pkg::ST_INIT)) ||
        (rq == 3'(wdg_pkg::ST_CONFIG) && (in_guard || in_run));

    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            base_cnt_q <= 4'h0;
            pre_cnt_q <= '0;
        end else begin
            base_cnt_q <= base_tick ? 4'h0 : base_cnt_q + 4'h1;
            if (wdg_tick)
                pre_cnt_q <= '0;
            else if (base_tick)
                pre_cnt_q <= pre_cnt_q + WIDTH'(1);
        end
    end

    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            prescaler_q <= WIDTH'(`PRESCALER_RST);
            local_time_q <= WIDTH'(`LOCAL_WDG_RST);
            bus_time_q <= WIDTH'(`BUS_WDG_RST);
            safe_q <= '0;
        end else if (reg_wr) begin
            if (LINK.addr == `PRESCALER_OFS)
                prescaler_q <= LINK.wdata[WIDTH-1:0];
            if (LINK.addr == `LOCAL_WDG_OFS)
                local_time_q <= LINK.wdata[WIDTH-1:0];
            if (LINK.addr == `BUS_WDG_OFS)
                bus_time_q <= LINK.wdata[WIDTH-1:0];
            if (LINK.addr == `SAFE_VALUE_OFS)
                safe_q <= wlow;
        end
    end

    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            bus_cnt_q <= '0;
            bus_exp_q <= 1'b0;
        end else if (proc_done || !bus_en) begin
            bus_cnt_q <= '0;
            bus_exp_q <= 1'b0;
        end else if (wdg_tick && !bus_exp_q) begin
            bus_cnt_q <= bus_cnt_q + WIDTH'(1);
            bus_exp_q <= bus_cnt_q + WIDTH'(1) >= bus_time_q;
        end
    end

    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            local_cnt_q <= '0;
            local_exp_q <= 1'b0;
        end else if (LOCAL_ACCESS || !local_en) begin
            local_cnt_q <= '0;
            local_exp_q <= 1'b0;
        end else if (wdg_tick && !local_exp_q) begin
            local_cnt_q <= local_cnt_q + WIDTH'(1);
            local_exp_q <= local_cnt_q + WIDTH'(1) >= local_time_q;
        end
    end

    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            state_q <= wdg_pkg::ST_INIT;
        end else if (st_wr) begin
            if (go_cfg || go_boot || go_guard || go_run || go_down)
                state_q <= wdg_pkg::slave_state_t'(rq);
        end
    end

    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B)
            image_q <= '0;
        else if ((st_wr && go_guard) || proc_ok)
            image_q <= INPUTS;
    end

    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            out_data_q <= '0;
            outputs_q <= '0;
        end else begin
            if (proc_wr)
                out_data_q <= wlow;
            if (in_run && !bus_exp_q && !local_exp_q)
                outputs_q <= out_data_q;
            else
                outputs_q <= safe_q;
        end
    end

    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            ack_q <= 1'b0;
            err_q <= 1'b0;
            rdata_q <= 16'h0000;
        end else begin
            ack_q <= take;
            err_q <= take && !allowed;
            rdata_q <= rd_mux;
        end
    end

    assign LINK.ack = ack_q;
    assign LINK.err = err_q;
    assign LINK.rdata = rdata_q;
    assign OUTPUTS = outputs_q;
    assign INPUT_IMAGE = image_q;
    assign BUS_WDG_EXPIRED = bus_exp_q;
    assign LOCAL_WDG_EXPIRED = local_exp_q;
    assign STATE = state_q;
endmodule

/* File: bus_master.sv */
// Bus master end: one access at a time toward the slave controller
`timescale 1ns/100ps
`include "wdg_map.svh"
module bus_master (
    input wire logic REF_CLK,
    input wire logic RST_B,
    slave_link_if.master LINK,
    input wire logic CMD_VALID,
    input wire logic CMD_WR,
    input wire logic [1:0] CMD_KIND,
    input wire logic [15:0] CMD_ADDR,
    input wire logic [15:0] CMD_WDATA,
    input wire logic CMD_TIMER_EN,
    output logic CMD_READY,
    output logic DONE,
    output logic DONE_ERR,
    output logic [15:0] DONE_RDATA
);
    logic busy_q, req_q, wr_q, done_q, derr_q, ready_q;
    logic [1:0] kind_q;
    logic [15:0] addr_q, wdata_q, drd_q;
    wire is_timer = CMD_ADDR == `PRESCALER_OFS ||
        CMD_ADDR == `LOCAL_WDG_OFS || CMD_ADDR == `BUS_WDG_OFS;
    wire skip = CMD_WR && is_timer && !CMD_TIMER_EN;
    wire start = CMD_VALID && !busy_q && !skip;

    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            busy_q <= 1'b0;
            req_q <= 1'b0;
            wr_q <= 1'b0;
            kind_q <= 2'h0;
            addr_q <= 16'h0000;
            wdata_q <= 16'h0000;
            done_q <= 1'b0;
            derr_q <= 1'b0;
            drd_q <= 16'h0000;
            ready_q <= 1'b0;
        end else begin
            done_q <= 1'b0;
            ready_q <= !busy_q && !start;
            if (start) begin
                busy_q <= 1'b1;
                req_q <= 1'b1;
                wr_q <= CMD_WR;
                kind_q <= CMD_KIND;
                addr_q <= CMD_ADDR;
                wdata_q <= CMD_WDATA;
            end else if (CMD_VALID && !busy_q) begin
                done_q <= 1'b1;
                derr_q <= 1'b0;
            end
            if (LINK.ack) begin
                req_q <= 1'b0;
                busy_q <= 1'b0;
                done_q <= 1'b1;
                derr_q <= LINK.err;
                drd_q <= LINK.rdata;
            end
        end
    end

    assign LINK.req = req_q;
    assign LINK.wr = wr_q;
    assign LINK.kind = wdg_pkg::access_kind_t'(kind_q);
    assign LINK.addr = addr_q;
    assign LINK.wdata = wdata_q;
    assign CMD_READY = ready_q;
    assign DONE = done_q;
    assign DONE_ERR = derr_q;
    assign DONE_RDATA = drd_q;
endmodule

/* File: link_props.sv */
// Timing and register read-back checks on the master to slave link
`timescale 1ns/100ps
`include "wdg_map.svh"
module link_props (
    input wire logic REF_CLK,
    input wire logic RST_B,
    input wire logic req,
    input wire logic wr,
    input wire wdg_pkg::access_kind_t kind,
    input wire logic [15:0] addr,
    input wire logic [15:0] wdata,
    input wire logic ack,
    input wire logic err,
    input wire logic [15:0] rdata
);
    logic [15:0] pre_q;
    logic [15:0] bus_q;
    wire reg_ok = ack && !err && kind == wdg_pkg::KIND_REG;
    wire rd_ok = reg_ok && !wr;
    // Shadow of the prescaler and bus timer registers as written over the link
    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            pre_q <= `PRESCALER_RST;
            bus_q <= `BUS_WDG_RST;
        end else if (reg_ok && wr && addr == `PRESCALER_OFS) begin
            pre_q <= wdata;
        end else if (reg_ok && wr && addr == `BUS_WDG_OFS) begin
            bus_q <= wdata;
        end
    end
    default clocking cb @(posedge REF_CLK);
    endclocking
    default disable iff (!RST_B);
    ack_latency_a: assert property ($rose(req) |=> ack)
        else $error("ack not one cycle after request");
    ack_pulse_a: assert property (ack |=> !ack)
        else $error("ack longer than one cycle");
    req_release_a: assert property (ack |=> !req)
        else $error("request kept after ack");
    req_hold_a: assert property (req && !ack |=> req && $stable(addr))
        else $error("request dropped or changed before ack");
    err_with_ack_a: assert property (err |-> ack)
        else $error("refusal without ack");
    reg_accept_a: assert property (
        ack && kind == wdg_pkg::KIND_REG |-> !err)
        else $error("register access refused");
    prescale_rb_a: assert property (
        rd_ok && addr == `PRESCALER_OFS |-> rdata == pre_q)
        else $error("prescaler read back wrong");
    bus_timer_rb_a: assert property (
        rd_ok && addr == `BUS_WDG_OFS |-> rdata == bus_q)
        else $error("bus timer read back wrong");
    unmapped_zero_a: assert property (
        rd_ok && addr == 16'h0200 |-> rdata == 16'h0000)
        else $error("unmapped read not zero");
    cover property (ack && err);
    cover property (reg_ok && wr && addr == `STATE_REQ_OFS);
    cover property (ack && !err && kind == wdg_pkg::KIND_PROCESS);
endmodule

/* File: test_slave_watchdog_and_state_control.sv */
// Bench for the master and slave controller ends joined by the link
`timescale 1ns/100ps
`include "wdg_map.svh"
module test_slave_watchdog_and_state_control;
    logic clk, rst_b, cv, cw, ten, la, mok, pok, rdy, done, derr, bexp, lexp;
    logic e;
    logic [1:0] ck;
    logic [15:0] ca, cd, drd, rd;
    logic [7:0] inp, outp, img;
    logic [2:0] st;
    int err_total = 0;
    int n_checks = 0;
    slave_link_if link();
    slave_controller i_slave_controller(.REF_CLK(clk), .RST_B(rst_b),
        .LINK(link.slave), .LOCAL_ACCESS(la), .MAILBOX_CFG_OK(mok),
        .PROCESS_CFG_OK(pok), .INPUTS(inp), .OUTPUTS(outp),
        .INPUT_IMAGE(img), .BUS_WDG_EXPIRED(bexp),
        .LOCAL_WDG_EXPIRED(lexp), .STATE(st));
    bus_master i_bus_master(.REF_CLK(clk), .RST_B(rst_b), .LINK(link.master),
        .CMD_VALID(cv), .CMD_WR(cw), .CMD_KIND(ck), .CMD_ADDR(ca),
        .CMD_WDATA(cd), .CMD_TIMER_EN(ten), .CMD_READY(rdy), .DONE(done),
        .DONE_ERR(derr), .DONE_RDATA(drd));
    link_props i_link_props(.REF_CLK(clk), .RST_B(rst_b), .req(link.req),
        .wr(link.wr), .kind(link.kind), .addr(link.addr), .wdata(link.wdata),
        .ack(link.ack), .err(link.err), .rdata(link.rdata));
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    task automatic complete_run();
        $display("Checks %0d, errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [15:0] x,
        input logic [15:0] g);
        n_checks++;
        if (g !== x) begin
            err_total++;
            $display("Error %s expected %h seen %h", nm, x, g);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // One command through the master, result kept in e and rd
    task automatic acc(input logic w, input logic [1:0] k,
        input logic [15:0] a, input logic [15:0] d);
        int n;
        @(posedge clk);
        cv <= 1'b1;
        cw <= w;
        ck <= k;
        ca <= a;
        cd <= d;
        @(posedge clk);
        cv <= 1'b0;
        #1;
        for (n = 0; done !== 1'b1 && n < 80; n++) cyc(1);
        chk("done", 16'h0001, {15'h0000, done});
        if (done !== 1'b1) complete_run();
        e = derr;
        rd = drd;
        cyc(1);
    endtask
    task automatic rdr(input logic [15:0] a, input logic [15:0] x);
        acc(1'b0, 2'h0, a, 16'h0000);
        chk("reg read", x, rd);
    endtask
    task automatic go(input logic [2:0] v, input logic [2:0] x);
        acc(1'b1, 2'h0, `STATE_REQ_OFS, {13'h0000, v});
        cyc(1);
        chk("state", {13'h0000, x}, {13'h0000, st});
    endtask
    task automatic kinds(input logic [3:0] m);
        for (int k = 1; k < 4; k++) begin
            acc(1'b0, 2'(k), `OUT_DATA_OFS, 16'h0000);
            chk("refused", {15'h0000, m[k]}, {15'h0000, e});
        end
    endtask
    task automatic s_init();
        chk("state", 16'h0001, {13'h0000, st});
        chk("ready", 16'h0001, {15'h0000, rdy});
        rdr(`PRESCALER_OFS, `PRESCALER_RST);
        rdr(`BUS_WDG_OFS, `BUS_WDG_RST);
        rdr(16'h0200, 16'h0000);
        kinds(4'hE);
        acc(1'b1, 2'h0, `PRESCALER_OFS, 16'h0000);
        rdr(`PRESCALER_OFS, `PRESCALER_RST);
        acc(1'b1, 2'h0, `SAFE_VALUE_OFS, 16'h003C);
        go(3'h3, 3'h3);
        kinds(4'hA);
        go(3'h4, 3'h3);
        go(3'h1, 3'h1);
    endtask
    task automatic s_config();
        go(3'h2, 3'h1);
        @(posedge clk);
        mok <= 1'b1;
        go(3'h2, 3'h2);
        kinds(4'h8);
        go(3'h3, 3'h2);
        go(3'h4, 3'h2);
        @(posedge clk);
        pok <= 1'b1;
        go(3'h4, 3'h4);
        chk("image", 16'h0096, {8'h00, img});
        acc(1'b1, 2'h3, `OUT_DATA_OFS, 16'h00A5);
        chk("outputs", 16'h003C, {8'h00, outp});
        @(posedge clk);
        inp <= 8'h69;
        acc(1'b0, 2'h3, `OUT_DATA_OFS, 16'h0000);
        chk("image", 16'h0069, rd);
        kinds(4'h0);
    endtask
    task automatic s_wdg();
        int n;
        go(3'h0, 3'h0);
        chk("outputs", 16'h00A5, {8'h00, outp});
        kinds(4'h0);
        @(posedge clk);
        ten <= 1'b1;
        la <= 1'b1;
        acc(1'b1, 2'h0, `PRESCALER_OFS, 16'h0000);
        acc(1'b1, 2'h0, `BUS_WDG_OFS, 16'h0002);
        rdr(`BUS_WDG_OFS, 16'h0002);
        acc(1'b1, 2'h0, `LOCAL_WDG_OFS, 16'h0002);
        acc(1'b1, 2'h3, `OUT_DATA_OFS, 16'h005A);
        chk("outputs", 16'h005A, {8'h00, outp});
        @(posedge clk);
        la <= 1'b0;
        for (n = 0; bexp !== 1'b1 && n < 80; n++) cyc(1);
        chk("expiry time", 16'h0001, {15'h0000, n >= 8 && n <= 50});
        cyc(20);
        chk("local expired", 16'h0001, {15'h0000, lexp});
        chk("state", 16'h0000, {13'h0000, st});
        chk("outputs", 16'h003C, {8'h00, outp});
        chk("bus expired", 16'h0001, {15'h0000, bexp});
        @(posedge clk);
        la <= 1'b1;
        @(posedge clk);
        la <= 1'b0;
        cyc(1);
        chk("local expired", 16'h0000, {15'h0000, lexp});
        acc(1'b1, 2'h3, `OUT_DATA_OFS, 16'h005A);
        chk("bus expired", 16'h0000, {15'h0000, bexp});
        acc(1'b1, 2'h0, `BUS_WDG_OFS, 16'h0000);
        acc(1'b1, 2'h0, `LOCAL_WDG_OFS, 16'h0000);
        cyc(100);
        chk("bus expired", 16'h0000, {15'h0000, bexp});
        chk("outputs", 16'h005A, {8'h00, outp});
    endtask
    initial begin
        rst_b = 1'b0;
        {cv, cw, ten, la, mok, pok} = 6'h00;
        ck = 2'h0;
        ca = 16'h0000;
        cd = 16'h0000;
        inp = 8'h96;
        repeat (16) @(posedge clk);
        rst_b <= 1'b1;
        cyc(1);
        s_init();
        s_config();
        s_wdg();
        complete_run();
    end
endmodule
